/* logic/eaat_ctrl.sv */
// External area access timing controller with AXI4-Lite configuration slave
// Contract
// - Strobe follows address and select by setup field bits 12:11 delay.
// - Wait field bits 10:7 inserts 0-6,8,10,12,14,18,24 access wait cycles.
// - Bit 6 clear honours external wait; set ignores it entirely.
// - Wait mask applies even when access wait count is zero.
// - Address and select held after strobe by hold field bits 1:0.
// - Reserved bits 31:13 and 5:2 read zero; software writes zero.
//
// Our own choices: the AXI4-Lite interface to the registers and the register offsets.
`timescale 1ns/1ps
module eaat_ctrl
   import eaat_pkg::*;
#(
   parameter int ADDR_W = 26,
   parameter int DATA_W = 16
) (
   // Clock and reset
   input  wire logic              CLK_I,
   input  wire logic              RESETN_I,
   // AXI4-Lite write
   input  wire logic [31:0]       AWADDR_I,
   input  wire logic              AWVALID_I,
   output logic                   AWREADY_O,
   input  wire logic [31:0]       WDATA_I,
   input  wire logic [3:0]        WSTRB_I,
   input  wire logic              WVALID_I,
   output logic                   WREADY_O,
   output logic [1:0]             BRESP_O,
   output logic                   BVALID_O,
   input  wire logic              BREADY_I,
   // AXI4-Lite read
   input  wire logic [31:0]       ARADDR_I,
   input  wire logic              ARVALID_I,
   output logic                   ARREADY_O,
   output logic [31:0]            RDATA_O,
   output logic [1:0]             RRESP_O,
   output logic                   RVALID_O,
   input  wire logic              RREADY_I,
   // On-chip access request
   input  wire logic              REQ_I,
   input  wire logic              REQ_WRITE_I,
   input  wire logic [ADDR_W-1:0] REQ_ADDR_I,
   input  wire logic [DATA_W-1:0] REQ_WDATA_I,
   output logic                   REQ_READY_O,
   output logic                   REQ_DONE_O,
   output logic [DATA_W-1:0]      REQ_RDATA_O,
   // External memory pins
   output logic                   CHIP_SELECT_N_O,
   output logic                   RD_N_O,
   output logic                   WE_N_O,
   output logic [ADDR_W-1:0]      ADDR_O,
   output logic [DATA_W-1:0]      DATA_O,
   output logic                   DATA_OE_O,
   input  wire logic [DATA_W-1:0] DATA_I,
   input  wire logic              EXT_WAIT_I
);
   // ==========================================================
   // Elaboration check
   if (DATA_W < 1 || DATA_W > 32 || ADDR_W < 1 || ADDR_W > 32) begin : g_chk
      $error("eaat_ctrl: unsupported width");
   end

   // ==========================================================
   // Declarations
   eaat_cfg_t             cfg_r;
   eaat_state_t           st_r;
   logic [EAAT_CNT_W-1:0] cnt_r;
   logic                  is_wr_r;
   logic                  wait_m_r;
   logic                  wait_s_r;
   logic [DATA_W-1:0]     din_m_r;
   logic [DATA_W-1:0]     din_s_r;
   logic                  aw_got_r;
   logic                  w_got_r;
   logic [31:0]           awaddr_r;
   logic [31:0]           wdata_r;
   logic [3:0]            wstrb_r;
   logic [31:0]           wmask;
   logic                  strobe_end;
   logic [4:0]            setup_len;
   logic [4:0]            strobe_len;
   logic [4:0]            hold_len;
   logic [4:0]            ph_len_r;
   logic                  cfg_written_r;

   assign setup_len  = {3'h0, cfg_r.strobe_setup_delay} + EAAT_ONE;
   assign strobe_len = eaat_wait_cycles(cfg_r.access_wait_count) + EAAT_ONE;
   assign hold_len   = {3'h0, cfg_r.strobe_hold_delay} + EAAT_ONE;
   assign strobe_end = (cnt_r == EAAT_ONE) && (cfg_r.ext_wait_ignore || !wait_s_r);
   assign wmask = {{8{wstrb_r[3]}}, {8{wstrb_r[2]}}, {8{wstrb_r[1]}}, {8{wstrb_r[0]}}}
                  & EAAT_CFG_WMASK;

   // ==========================================================
   // Pin synchronisers
   always_ff @(posedge CLK_I or negedge RESETN_I) begin
      if (!RESETN_I) begin
         wait_m_r <= 1'b0;
         wait_s_r <= 1'b0;
         din_m_r  <= '0;
         din_s_r  <= '0;
      end else begin
         wait_m_r <= EXT_WAIT_I;
         wait_s_r <= wait_m_r;
         din_m_r  <= DATA_I;
         din_s_r  <= din_m_r;
      end
   end

   // ==========================================================
   // Access sequencer
   always_ff @(posedge CLK_I or negedge RESETN_I) begin
      if (!RESETN_I) begin
         st_r    <= ST_IDLE;
         cnt_r   <= '0;
         is_wr_r <= 1'b0;
      end else begin
         case (st_r)
            ST_IDLE: begin
               if (REQ_I) begin
                  st_r    <= ST_SETUP;
                  is_wr_r <= REQ_WRITE_I;
                  cnt_r   <= setup_len;
               end
            end
            ST_SETUP: begin
               if (cnt_r == EAAT_ONE) begin
                  st_r  <= ST_STROBE;
                  cnt_r <= strobe_len;
               end else begin
                  cnt_r <= cnt_r - EAAT_ONE;
               end
            end
            ST_STROBE: begin
               // External wait stretches even zero-wait access
               if (strobe_end) begin
                  st_r  <= ST_HOLD;
                  cnt_r <= hold_len;
               end else if (cnt_r != EAAT_ONE) begin
                  cnt_r <= cnt_r - EAAT_ONE;
               end
            end
            ST_HOLD: begin
               if (cnt_r == EAAT_ONE) begin
                  st_r <= ST_IDLE;
               end else begin
                  cnt_r <= cnt_r - EAAT_ONE;
               end
            end
            default: begin
               st_r <= ST_IDLE;
            end
         endcase
      end
   end

   // ==========================================================
   // Pin and request outputs, all registered to avoid glitches on the strobes
   always_ff @(posedge CLK_I or negedge RESETN_I) begin
      if (!RESETN_I) begin
         CHIP_SELECT_N_O <= 1'b1;
         RD_N_O          <= 1'b1;
         WE_N_O          <= 1'b1;
         ADDR_O          <= '0;
         DATA_O          <= '0;
         DATA_OE_O       <= 1'b0;
         REQ_READY_O     <= 1'b0;
         REQ_DONE_O      <= 1'b0;
         REQ_RDATA_O     <= '0;
      end else begin
         REQ_DONE_O  <= 1'b0;
         REQ_READY_O <= (st_r == ST_IDLE) && !REQ_I;
         if (st_r == ST_IDLE && REQ_I) begin
            CHIP_SELECT_N_O <= 1'b0;
            ADDR_O          <= REQ_ADDR_I;
            DATA_O          <= REQ_WDATA_I;
            DATA_OE_O       <= REQ_WRITE_I;
            REQ_READY_O     <= 1'b0;
         end
         if (st_r == ST_SETUP && cnt_r == EAAT_ONE) begin
            RD_N_O <= is_wr_r;
            WE_N_O <= !is_wr_r;
         end
         if (st_r == ST_STROBE && strobe_end) begin
            RD_N_O      <= 1'b1;
            WE_N_O      <= 1'b1;
            REQ_RDATA_O <= is_wr_r ? REQ_RDATA_O : din_s_r;
         end
         if (st_r == ST_HOLD && cnt_r == EAAT_ONE) begin
            CHIP_SELECT_N_O <= 1'b1;
            DATA_OE_O       <= 1'b0;
            REQ_DONE_O      <= 1'b1;
         end
      end
   end

   // ==========================================================
   // AXI4-Lite write channel; address and data taken in either order
   always_ff @(posedge CLK_I or negedge RESETN_I) begin
      if (!RESETN_I) begin
         aw_got_r  <= 1'b0;
         w_got_r   <= 1'b0;
         awaddr_r  <= '0;
         wdata_r   <= '0;
         wstrb_r   <= '0;
         AWREADY_O <= 1'b0;
         WREADY_O  <= 1'b0;
         BVALID_O  <= 1'b0;
         BRESP_O   <= EAAT_RESP_OKAY;
      end else begin
         AWREADY_O <= !aw_got_r && !(AWVALID_I && AWREADY_O) && !BVALID_O;
         WREADY_O  <= !w_got_r && !(WVALID_I && WREADY_O) && !BVALID_O;
         if (AWVALID_I && AWREADY_O) begin
            aw_got_r <= 1'b1;
            awaddr_r <= AWADDR_I;
         end
         if (WVALID_I && WREADY_O) begin
            w_got_r <= 1'b1;
            wdata_r <= WDATA_I;
            wstrb_r <= WSTRB_I;
         end
         if (aw_got_r && w_got_r && !BVALID_O) begin
            aw_got_r <= 1'b0;
            w_got_r  <= 1'b0;
            BVALID_O <= 1'b1;
            BRESP_O  <= (awaddr_r[31:2] == EAAT_CFG_OFFSET[31:2]) ? EAAT_RESP_OKAY
                                                               : EAAT_RESP_SLVERR;
         end else if (BVALID_O && BREADY_I) begin
            BVALID_O <= 1'b0;
         end
      end
   end

   // ==========================================================
   // Configuration register; live values steer the next phase loaded
   always_ff @(posedge CLK_I or negedge RESETN_I) begin
      if (!RESETN_I) begin
         cfg_r         <= eaat_cfg_t'(EAAT_CFG_RESET);
         cfg_written_r <= 1'b0;
      end else if (aw_got_r && w_got_r && !BVALID_O
                   && awaddr_r[31:2] == EAAT_CFG_OFFSET[31:2]) begin
         cfg_r         <= eaat_cfg_t'((cfg_r & ~wmask) | (wdata_r & wmask));
         cfg_written_r <= 1'b1;
      end
   end

   // ==========================================================
   // AXI4-Lite read channel
   always_ff @(posedge CLK_I or negedge RESETN_I) begin
      if (!RESETN_I) begin
         ARREADY_O <= 1'b0;
         RVALID_O  <= 1'b0;
         RDATA_O   <= '0;
         RRESP_O   <= EAAT_RESP_OKAY;
      end else begin
         ARREADY_O <= !RVALID_O && !(ARVALID_I && ARREADY_O);
         if (ARVALID_I && ARREADY_O) begin
            RVALID_O <= 1'b1;
            if (ARADDR_I[31:2] == EAAT_CFG_OFFSET[31:2]) begin
               RDATA_O <= cfg_r & EAAT_CFG_WMASK;
               RRESP_O <= EAAT_RESP_OKAY;
            end else begin
               RDATA_O <= '0;
               RRESP_O <= EAAT_RESP_SLVERR;
            end
         end else if (RVALID_O && RREADY_I) begin
            RVALID_O <= 1'b0;
         end
      end
   end

   // ==========================================================
   // Checks
   always_ff @(posedge CLK_I or negedge RESETN_I) begin
      if (!RESETN_I) begin
         ph_len_r <= '0;
      end else if (st_r == ST_IDLE || $changed(st_r)) begin
         ph_len_r <= EAAT_ONE;
      end else begin
         ph_len_r <= ph_len_r + EAAT_ONE;
      end
   end

   default clocking cb @(posedge CLK_I); endclocking
   default disable iff (!RESETN_I);

   setup_len_a: assert property ((st_r == ST_SETUP) ##1 (st_r == ST_STROBE) |->
      ph_len_r == $past(setup_len)) else $error("setup phase length wrong");
   wait_len_a: assert property ((st_r == ST_STROBE) && cfg_r.ext_wait_ignore
      && $stable(cfg_r) ##1 (st_r == ST_HOLD) |-> ph_len_r == $past(strobe_len))
      else $error("strobe phase length wrong");
   wait_honour_a: assert property ((st_r == ST_STROBE) && !cfg_r.ext_wait_ignore
      && wait_s_r |=> st_r == ST_STROBE && !RD_N_O != !WE_N_O)
      else $error("external wait not honoured");
   wait_ignore_a: assert property ((st_r == ST_STROBE) && cfg_r.ext_wait_ignore
      && cnt_r == EAAT_ONE |=> st_r == ST_HOLD) else $error("external wait not ignored");
   zero_wait_a: assert property ((st_r == ST_STROBE) && cfg_r.access_wait_count == 4'h0
      && !cfg_r.ext_wait_ignore && wait_s_r |=> st_r == ST_STROBE)
      else $error("zero wait access not stretched");
   hold_len_a: assert property ((st_r == ST_HOLD) ##1 (st_r == ST_IDLE) |->
      ph_len_r == $past(hold_len) && CHIP_SELECT_N_O && RD_N_O && WE_N_O)
      else $error("hold phase length wrong");
   rsv_read_a: assert property (RVALID_O |->
      RDATA_O[31:13] == 19'h0 && RDATA_O[5:2] == 4'h0) else $error("reserved bits read set");
   reset_val_a: assert property (!cfg_written_r |->
      cfg_r == eaat_cfg_t'(EAAT_CFG_RESET)) else $error("reset value lost");
endmodule

/* inc/eaat_pkg.sv */
// Constants, types and lookup shared by the external area access timing block
package eaat_pkg;
   // ==========================================================
   // Register map
   localparam logic [31:0] EAAT_CFG_OFFSET = 32'h0000_0000;
   localparam logic [31:0] EAAT_CFG_RESET  = 32'h0000_0500;
   localparam logic [31:0] EAAT_CFG_WMASK  = 32'h0000_1fc3;
   localparam logic [1:0]  EAAT_RESP_OKAY  = 2'h0;
   localparam logic [1:0]  EAAT_RESP_SLVERR = 2'h2;
   // ==========================================================
   // Timing
   localparam int          EAAT_CNT_W      = 5;
   localparam logic [4:0]  EAAT_ONE        = 5'h01;
   // ==========================================================
   // Types
   typedef struct packed {
      logic [18:0] rsv_hi;
      logic [1:0]  strobe_setup_delay;
      logic [3:0]  access_wait_count;
      logic        ext_wait_ignore;
      logic [3:0]  rsv_lo;
      logic [1:0]  strobe_hold_delay;
   } eaat_cfg_t;
   typedef enum logic [3:0] {
      ST_IDLE   = 4'h1,
      ST_SETUP  = 4'h2,
      ST_STROBE = 4'h4,
      ST_HOLD   = 4'h8
   } eaat_state_t;
   // ==========================================================
   // Wait code to cycles; prohibited codes fall back to the longest wait
   function automatic logic [4:0] eaat_wait_cycles(input logic [3:0] code);
      logic [4:0] n;
      n = 5'h18;
      case (code)
         4'h0: n = 5'h00;
         4'h1: n = 5'h01;
         4'h2: n = 5'h02;
         4'h3: n = 5'h03;
         4'h4: n = 5'h04;
         4'h5: n = 5'h05;
         4'h6: n = 5'h06;
         4'h7: n = 5'h08;
         4'h8: n = 5'h0a;
         4'h9: n = 5'h0c;
         4'ha: n = 5'h0e;
         4'hb: n = 5'h12;
         default: n = 5'h18;
      endcase
      return n;
   endfunction
endpackage

/* verification/eaat_sram_model.sv */
// Behavioural external memory with a wait output for one select area
`timescale 1ns/1ps
module eaat_sram_model #(
   parameter int WAIT_LEN = 6
) (
   input  wire logic        clk_i,
   input  wire logic [25:0] addr_i,
   input  wire logic        cs_n_i,
   input  wire logic        rd_n_i,
   input  wire logic        we_n_i,
   input  wire logic [15:0] data_i,
   input  wire logic        data_oe_i,
   output logic [15:0]      data_o,
   output logic             wait_o
);
   logic [15:0] mem_r [16];
   logic [15:0] last_r;
   int          cnt_r;
   // ==========================================================
   // Drive only while selected and read; else no stale value
   assign data_o = (!cs_n_i && !rd_n_i) ? mem_r[addr_i[3:0]] : ~last_r;
   // Slow device: wait asserted for the first cycles of each select
   assign wait_o = !cs_n_i && (cnt_r < WAIT_LEN);
   always @(posedge clk_i) begin
      cnt_r <= cs_n_i ? 0 : cnt_r + 1;
      last_r <= data_o;
      if (!cs_n_i && !we_n_i && data_oe_i) begin
         mem_r[addr_i[3:0]] <= data_i;
      end
   end
endmodule

/* verification/external_area_access_timing_test.sv */
// Self-checking bench of the external area access timing controller
`timescale 1ns/1ps
module external_area_access_timing_test;
   import eaat_pkg::*;
   logic        clk, rst_n, awvalid, wvalid, bready, arvalid, rready, req, req_write;
   logic        awready, wready, bvalid, arready, rvalid, req_ready, req_done;
   logic        cs_n, rd_n, we_n, data_oe, ext_wait, seen;
   logic [31:0] awaddr, wdata, araddr, rdata, seed, d, cfg;
   logic [1:0]  bresp, rresp, r, s, h;
   logic [25:0] req_addr, addr, a;
   logic [15:0] req_wdata, req_rdata, data_out, data_in, dv;
   int          fail_count, n_compared, cyc, su, wd, ho;
   int          wt [13] = '{0, 1, 2, 3, 4, 5, 6, 8, 10, 12, 14, 18, 24};
   eaat_ctrl dut (.CLK_I(clk), .RESETN_I(rst_n), .AWADDR_I(awaddr), .AWVALID_I(awvalid),
      .AWREADY_O(awready), .WDATA_I(wdata), .WSTRB_I(4'hf), .WVALID_I(wvalid),
      .WREADY_O(wready), .BRESP_O(bresp), .BVALID_O(bvalid), .BREADY_I(bready),
      .ARADDR_I(araddr), .ARVALID_I(arvalid), .ARREADY_O(arready), .RDATA_O(rdata),
      .RRESP_O(rresp), .RVALID_O(rvalid), .RREADY_I(rready), .REQ_I(req),
      .REQ_WRITE_I(req_write), .REQ_ADDR_I(req_addr), .REQ_WDATA_I(req_wdata),
      .REQ_READY_O(req_ready), .REQ_DONE_O(req_done), .REQ_RDATA_O(req_rdata),
      .CHIP_SELECT_N_O(cs_n), .RD_N_O(rd_n), .WE_N_O(we_n), .ADDR_O(addr),
      .DATA_O(data_out), .DATA_OE_O(data_oe), .DATA_I(data_in), .EXT_WAIT_I(ext_wait));
   eaat_sram_model mem (.clk_i(clk), .addr_i(addr), .cs_n_i(cs_n), .rd_n_i(rd_n),
      .we_n_i(we_n), .data_i(data_out), .data_oe_i(data_oe), .data_o(data_in),
      .wait_o(ext_wait));
   // ==========================================================
   // Clock, timeout and strobe phase monitor
   initial begin
      clk = 1'b0;
      forever #12.5 clk = ~clk;
   end
   always @(posedge clk) begin
      cyc++;
      if (cyc == 60000) begin
         fail_count++;
         finish_test();
      end
      if (!cs_n && rd_n && we_n) begin
         if (seen) ho++;
         else su++;
      end
      if (!(rd_n && we_n)) begin
         wd++;
         seen = 1'b1;
      end
   end
   // ==========================================================
   // Shared tasks
   function automatic logic [31:0] xs(input logic [31:0] v);
      v ^= v << 13;
      v ^= v >> 17;
      v ^= v << 5;
      return v;
   endfunction
   task automatic check(input logic [31:0] got, input logic [31:0] exp);
      n_compared++;
      if (got !== exp) begin
         fail_count++;
         $display("wrong value at %0t: got %h expected %h", $time, got, exp);
      end
   endtask
   task automatic axi_wr(input logic [31:0] ad, input logic [31:0] dt, output logic [1:0] rs);
      awaddr <= ad;
      wdata <= dt;
      awvalid <= 1'b1;
      wvalid <= 1'b1;
      bready <= 1'b1;
      do begin
         @(posedge clk);
         if (awready) awvalid <= 1'b0;
         if (wready) wvalid <= 1'b0;
      end while (!bvalid);
      rs = bresp;
      bready <= 1'b0;
      @(posedge clk);
   endtask
   task automatic axi_rd(input logic [31:0] ad, output logic [31:0] dt, output logic [1:0] rs);
      araddr <= ad;
      arvalid <= 1'b1;
      rready <= 1'b1;
      do begin
         @(posedge clk);
         if (arready) arvalid <= 1'b0;
      end while (!rvalid);
      dt = rdata;
      rs = rresp;
      rready <= 1'b0;
      @(posedge clk);
   endtask
   task automatic access(input logic wr, input logic [25:0] ad, input logic [15:0] dt);
      int n;
      req <= 1'b1;
      req_write <= wr;
      req_addr <= ad;
      req_wdata <= dt;
      do @(posedge clk); while (!req_ready);
      req <= 1'b0;
      su = 0;
      wd = 0;
      ho = 0;
      seen = 1'b0;
      n = 0;
      do begin
         @(posedge clk);
         n++;
      end while (!req_done && n < 300);
   endtask
   task automatic finish_test();
      if (fail_count == 0 && n_compared > 0) $display("ALL CHECKS OK");
      else $display("CHECKS NOT OK");
      $finish;
   endtask
   // ==========================================================
   // Main sequence
   initial begin
      {rst_n, awvalid, wvalid, bready, arvalid, rready, req, req_write} = '0;
      {awaddr, wdata, araddr, req_addr, req_wdata} = '0;
      {fail_count, n_compared, cyc, su, wd, ho, seen} = '0;
      seed = 32'h7e0a9fd7;
      repeat (6) @(posedge clk);
      rst_n <= 1'b1;
      @(posedge clk);
      axi_rd(32'h0, d, r);
      check(d, 32'h0000_0500);
      // Reserved bits set on write, a near all-ones pattern with longest wait code 0xc
      axi_wr(32'h0, 32'hffff_fe7f, r);
      axi_rd(32'h0, d, r);
      check(d, 32'h0000_1e43);
      axi_wr(32'h10, 32'h0, r);
      check(r, 2'h2);
      axi_rd(32'h10, d, r);
      check(r, 2'h2);
      check(d, 32'h0);
      axi_rd(32'h0, d, r);
      check(r, 2'h0);
      check(d, 32'h0000_1e43);
      // Wait codes 0 to 0xc, random setup and hold, external wait masked
      for (int c = 0; c < 13; c++) begin
         seed = xs(seed);
         s = seed[1:0];
         h = seed[3:2];
         a = seed[29:4];
         dv = seed[31:16] ^ seed[15:0];
         cfg = {19'h0, s, c[3:0], 1'b1, 4'h0, h};
         axi_wr(32'h0, cfg, r);
         for (int k = 1; k >= 0; k--) begin
            access(k[0], a, dv);
            check(su, s + 1);
            check(wd, wt[c] + 1);
            check(ho, h + 1);
            if (k == 0 && wt[c] >= 2) check(req_rdata, dv);
         end
      end
      // External wait honoured, zero-wait code among them
      // Longest setup, so the synchronised wait arrives before the strobe ends
      for (int m = 0; m < 2; m++) begin
         axi_wr(32'h0, {19'h0, 2'h3, 4'(m * 3), 1'b0, 4'h0, 2'h0}, r);
         access(1'b0, 26'h5, 16'h0);
         check(wd > m * 3 + 1, 1);
         check(wd <= m * 3 + 10, 1);
      end
      finish_test();
   end
endmodule
